// ### rtl/tmc_pkg.sv
// Purpose: shared constants and types for the timer 2 control block
// Assumes: 8-bit special-function register bus, page 0
// Notes: bit positions refer to the timer2_control register
package tmc_pkg;
	localparam logic [3:0] TMC_PAGE = 4'h0;
	localparam logic [7:0] TMC_CTRL_ADDR = 8'hC8;
	localparam logic [7:0] TMC_RLL_ADDR = 8'hCA;
	localparam logic [7:0] TMC_RLH_ADDR = 8'hCB;
	localparam logic [7:0] TMC_CNTL_ADDR = 8'hCC;
	localparam logic [7:0] TMC_CNTH_ADDR = 8'hCD;
	localparam logic [7:0] TMC_CTRL_RST = 8'h00;
	localparam logic [7:0] TMC_BYTE_MAX = 8'hFF;
	localparam logic [7:0] TMC_BYTE_ZERO = 8'h00;
	localparam int TMC_HF_BIT = 7;
	localparam int TMC_LF_BIT = 6;
	localparam int TMC_LEN_BIT = 5;
	localparam int TMC_CEN_BIT = 4;
	localparam int TMC_SPLIT_BIT = 3;
	localparam int TMC_RUN_BIT = 2;
	localparam int TMC_XSEL_HI = 1;
	localparam int TMC_XSEL_LO = 0;
	localparam int TMC_CLK_HZ = 25000000;
	localparam logic [3:0] TMC_DIV12_LAST = 4'hB;
	localparam logic [3:0] TMC_DIV12_ZERO = 4'h0;
	localparam logic [2:0] TMC_RTC8_LAST = 3'h7;
	typedef enum logic [1:0] {
		TMC_X_SYS12_RTC = 2'b00,
		TMC_X_CMP_RTC = 2'b01,
		TMC_X_SYS12_CMP = 2'b10,
		TMC_X_RTC_CMP = 2'b11
	} tmc_xclk_t;
endpackage

// ### rtl/tmc_tick_if.sv
// Purpose: tick and capture pulses from the clock selector to the counter
// Assumes: all signals on i_mclk
// Notes: one-cycle pulses, except each tick stays high every cycle while its own system clock select is on
`timescale 1ns/1ns
`default_nettype none
interface tmc_tick_if;
	logic tick_lo;
	logic tick_hi;
	logic capture;
	modport src (output tick_lo, output tick_hi, output capture);
	modport dst (input tick_lo, input tick_hi, input capture);
endinterface
`default_nettype wire

// ### rtl/tmc_clk_sel.sv
// Purpose: synchronise external sources and form count and capture enables
// Assumes: rtc and comparator are asynchronous pins
// Notes: rtc must stay well below half of i_mclk to be seen
`timescale 1ns/1ns
`default_nettype none
module tmc_clk_sel import tmc_pkg::*; (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// sources
	input wire logic i_rtc_clk,
	input wire logic i_cmp_out,
	// selection
	input wire logic [1:0] i_xsel,
	input wire logic i_lo_sys,
	input wire logic i_hi_sys,
	// pulses
	tmc_tick_if.src o_tk
);
	typedef struct packed {
		logic [1:0] rtc_s;
		logic [1:0] cmp_s;
		logic rtc_o;
		logic cmp_o;
		logic [3:0] div12;
		logic [2:0] rtc8;
		logic tick_lo;
		logic tick_hi;
		logic capture;
	} tmc_sel_st_t;
	tmc_sel_st_t q, d;
	logic sys12, rtc_div8, cmp_rise, ext;
	////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		// first stage feeds only the second
		d.rtc_s = {q.rtc_s[0], i_rtc_clk};
		d.cmp_s = {q.cmp_s[0], i_cmp_out};
		d.rtc_o = q.rtc_s[1];
		d.cmp_o = q.cmp_s[1];
		sys12 = (q.div12 == TMC_DIV12_LAST);
		d.div12 = sys12 ? TMC_DIV12_ZERO : q.div12 + 4'h1;
		cmp_rise = q.cmp_s[1] & ~q.cmp_o;
		rtc_div8 = 1'b0;
		if (q.rtc_s[1] & ~q.rtc_o) begin
			d.rtc8 = q.rtc8 + 3'h1;
			rtc_div8 = (q.rtc8 == TMC_RTC8_LAST);
		end
		unique case (tmc_xclk_t'(i_xsel))
			TMC_X_SYS12_RTC: ext = sys12;
			TMC_X_CMP_RTC: ext = cmp_rise;
			TMC_X_SYS12_CMP: ext = sys12;
			TMC_X_RTC_CMP: ext = rtc_div8;
		endcase
		d.tick_lo = i_lo_sys | ext;
		d.tick_hi = i_hi_sys | ext;
		d.capture = i_xsel[TMC_XSEL_HI] ? cmp_rise : rtc_div8;
	end
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_tk.tick_lo = q.tick_lo;
	assign o_tk.tick_hi = q.tick_hi;
	assign o_tk.capture = q.capture;
endmodule
`default_nettype wire

// ### rtl/tmc_timer2.sv
// Purpose: timer 2 control register with its counting and capture logic
// Assumes: core bus gives byte and single-bit writes, page select and read strobe
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
// Contract
// - The high-byte overflow flag, bit 7, sets when the upper byte rolls from FF to 00 and stays until software clears it.
// - In 16-bit mode the high-byte overflow flag sets when the whole counter wraps from FFFF to 0000.
// - With timer interrupts enabled, a set high-byte overflow flag requests the interrupt.
// - The low-byte overflow flag, bit 6, sets on every low-byte wrap in any mode and hardware never clears it.
// - With bit 5 and timer interrupts both enabled, each low-byte overflow raises the interrupt.
// - Bit 4 at 1 puts the timer in capture mode, at 0 leaves it off.
// - The control register sits at C8 on page 0, allows single-bit writes and resets to zero.
// - Bit 3 at 1 runs two 8-bit auto-reload timers, at 0 one 16-bit auto-reload timer.
// - Bit 2 enables counting; in split mode it gates only the upper byte while the lower byte runs.
// - The two clock select bits pick the external count clock and the capture trigger.
// - Timer interrupts need the core enable; without it flags set but no interrupt is raised.
module tmc_timer2 import tmc_pkg::*; (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// special-function register bus
	input wire logic [3:0] i_sfr_page,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_bit_wr,
	input wire logic [2:0] i_sfr_bit_sel,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// core side controls
	input wire logic i_core_timer_irq_enable,
	input wire logic i_lo_system_clock_sel,
	input wire logic i_hi_system_clock_sel,
	// external sources
	input wire logic i_rtc_clk,
	input wire logic i_cmp_out,
	// interrupt
	output logic o_irq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] cnt_lo;
		logic [7:0] cnt_hi;
		logic [7:0] rl_lo;
		logic [7:0] rl_hi;
		logic [7:0] rdata;
		logic irq;
	} tmc_st_t;
	tmc_st_t q, d;
	tmc_tick_if tk ();
	logic split, run, cen, lo_step, lo_wrap, hi_step, hi_wrap, cap_ev, hf_set, lf_set;

	function automatic logic hit(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] o);
		hit = (pg == TMC_PAGE) && (a == o);
	endfunction

	tmc_clk_sel u_sel (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_rtc_clk(i_rtc_clk),
		.i_cmp_out(i_cmp_out),
		.i_xsel(q.ctrl[TMC_XSEL_HI:TMC_XSEL_LO]),
		.i_lo_sys(i_lo_system_clock_sel),
		.i_hi_sys(i_hi_system_clock_sel),
		.o_tk(tk.src)
	);
	////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		split = q.ctrl[TMC_SPLIT_BIT];
		run = q.ctrl[TMC_RUN_BIT];
		cen = q.ctrl[TMC_CEN_BIT];
		// low byte free-runs in split mode, follows run otherwise
		lo_step = tk.tick_lo & (split | run);
		lo_wrap = lo_step & (q.cnt_lo == TMC_BYTE_MAX);
		hi_step = split ? (tk.tick_hi & run) : lo_wrap;
		hi_wrap = hi_step & (q.cnt_hi == TMC_BYTE_MAX);
		cap_ev = cen & tk.capture;
		hf_set = hi_wrap | cap_ev;
		lf_set = lo_wrap;
		// software writes first, hardware counting overrides below
		if (i_sfr_wr) begin
			if (hit(i_sfr_page, i_sfr_addr, TMC_CTRL_ADDR)) d.ctrl = i_sfr_wdata;
			if (hit(i_sfr_page, i_sfr_addr, TMC_RLL_ADDR)) d.rl_lo = i_sfr_wdata;
			if (hit(i_sfr_page, i_sfr_addr, TMC_RLH_ADDR)) d.rl_hi = i_sfr_wdata;
			if (hit(i_sfr_page, i_sfr_addr, TMC_CNTL_ADDR)) d.cnt_lo = i_sfr_wdata;
			if (hit(i_sfr_page, i_sfr_addr, TMC_CNTH_ADDR)) d.cnt_hi = i_sfr_wdata;
		end else if (i_sfr_bit_wr && hit(i_sfr_page, i_sfr_addr, TMC_CTRL_ADDR)) begin
			d.ctrl[i_sfr_bit_sel] = i_sfr_wdata[0];
		end
		if (lo_step) begin
			// in 16-bit mode the low byte reloads only with the full wrap
			if (lo_wrap && (split || hi_wrap) && !cen) d.cnt_lo = q.rl_lo;
			else d.cnt_lo = q.cnt_lo + 8'h01;
		end
		if (hi_step) begin
			if (hi_wrap && !cen) d.cnt_hi = q.rl_hi;
			else d.cnt_hi = q.cnt_hi + 8'h01;
		end
		if (cap_ev) begin
			d.rl_lo = q.cnt_lo;
			d.rl_hi = q.cnt_hi;
		end
		// set wins over any software clear in the same cycle
		d.ctrl[TMC_HF_BIT] = d.ctrl[TMC_HF_BIT] | hf_set;
		d.ctrl[TMC_LF_BIT] = d.ctrl[TMC_LF_BIT] | lf_set;
		d.irq = i_core_timer_irq_enable & (q.ctrl[TMC_HF_BIT] |
			(q.ctrl[TMC_LEN_BIT] & q.ctrl[TMC_LF_BIT]));
		if (i_sfr_rd) begin
			if (hit(i_sfr_page, i_sfr_addr, TMC_CTRL_ADDR)) d.rdata = q.ctrl;
			else if (hit(i_sfr_page, i_sfr_addr, TMC_RLL_ADDR)) d.rdata = q.rl_lo;
			else if (hit(i_sfr_page, i_sfr_addr, TMC_RLH_ADDR)) d.rdata = q.rl_hi;
			else if (hit(i_sfr_page, i_sfr_addr, TMC_CNTL_ADDR)) d.rdata = q.cnt_lo;
			else if (hit(i_sfr_page, i_sfr_addr, TMC_CNTH_ADDR)) d.rdata = q.cnt_hi;
			else d.rdata = TMC_BYTE_ZERO;
		end
	end
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_sfr_rdata = q.rdata;
	assign o_irq = q.irq;
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	logic hf_clr_try;
	assign hf_clr_try = i_sfr_wr & hit(i_sfr_page, i_sfr_addr, TMC_CTRL_ADDR)
		& ~i_sfr_wdata[TMC_HF_BIT];

	a_hf_split_wrap: assert property (split && hi_wrap |=> q.ctrl[TMC_HF_BIT])
		else $error("high flag missed on split high wrap");
	a_hf_full_wrap: assert property (!split && lo_wrap && q.cnt_hi == TMC_BYTE_MAX && run
		|=> q.ctrl[TMC_HF_BIT] && q.cnt_hi == $past(q.rl_hi) || $past(cen))
		else $error("16-bit wrap did not set flag or reload");
	a_irq_high: assert property (q.ctrl[TMC_HF_BIT] && i_core_timer_irq_enable |=> o_irq)
		else $error("high flag did not raise interrupt");
	a_lf_set: assert property (lo_wrap |=> q.ctrl[TMC_LF_BIT])
		else $error("low flag missed on low wrap");
	a_irq_low: assert property (lo_wrap && q.ctrl[TMC_LEN_BIT] && !i_sfr_wr && !i_sfr_bit_wr
		##1 i_core_timer_irq_enable |=> o_irq)
		else $error("low overflow did not raise interrupt");
	a_cap_load: assert property (cap_ev && !i_sfr_wr
		|=> {q.rl_hi, q.rl_lo} == $past({q.cnt_hi, q.cnt_lo}))
		else $error("capture did not load reload bytes");
	// a reload value of FF on a wrap legally leaves the byte unchanged
	a_lo_free: assert property (split && !run && tk.tick_lo && !i_sfr_wr
		&& !(q.cnt_lo == TMC_BYTE_MAX && q.rl_lo == TMC_BYTE_MAX && !cen)
		|=> q.cnt_lo != $past(q.cnt_lo))
		else $error("split low byte stalled");
	a_hi_hold: assert property (split && !run && !cap_ev && !i_sfr_wr
		|=> q.cnt_hi == $past(q.cnt_hi))
		else $error("split high byte ran while stopped");
	a_no_core_irq: assert property (!i_core_timer_irq_enable |=> !o_irq)
		else $error("interrupt without core enable");
	a_set_wins: assert property (hf_set && hf_clr_try |=> q.ctrl[TMC_HF_BIT])
		else $error("clear beat a hardware set");
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench for the timer 2 control register block
// Assumes: page 0 register bus, 25 MHz clock, slow square waves on the sources
// Notes: expectations are worked out here, never read back from the design
`timescale 1ns/1ns
`default_nettype none
module tb_top import tmc_pkg::*; ();
	logic i_mclk, i_nrst, wr, bwr, rd, core_en, lo_sel, hi_sel, rtc, cmp, irq;
	logic [3:0] page;
	logic [7:0] addr, wdata, rdata, v, rh, r;
	logic [2:0] bsel;
	int err_total, checked, cycles;
	tmc_timer2 dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sfr_page(page), .i_sfr_addr(addr),
		.i_sfr_wr(wr), .i_sfr_bit_wr(bwr), .i_sfr_bit_sel(bsel), .i_sfr_rd(rd),
		.i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_core_timer_irq_enable(core_en),
		.i_lo_system_clock_sel(lo_sel), .i_hi_system_clock_sel(hi_sel), .i_rtc_clk(rtc),
		.i_cmp_out(cmp), .o_irq(irq));
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// strobes are one cycle wide, driven between rising edges
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_mclk);
		wr = 1'b0;
	endtask
	task automatic bit_wr(input logic [2:0] b, input logic val);
		@(negedge i_mclk);
		addr = TMC_CTRL_ADDR;
		bsel = b;
		wdata = {7'h00, val};
		bwr = 1'b1;
		@(negedge i_mclk);
		bwr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_mclk);
		addr = a;
		rd = 1'b1;
		@(negedge i_mclk);
		rd = 1'b0;
		d = rdata;
	endtask
	// slow pulses so the two-stage synchroniser sees every edge
	task automatic pulse(input logic use_cmp, input int n);
		repeat (n) begin
			if (use_cmp) cmp = 1'b1;
			else rtc = 1'b1;
			repeat (4) @(negedge i_mclk);
			cmp = 1'b0;
			rtc = 1'b0;
			repeat (4) @(negedge i_mclk);
		end
		repeat (4) @(negedge i_mclk);
	endtask
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{i_nrst, wr, bwr, rd, core_en, lo_sel, hi_sel, rtc, cmp} = 9'h000;
		{page, addr, wdata, bsel} = 23'h000000;
		err_total = 0;
		checked = 0;
		cycles = 0;
		v = 8'($urandom(32'h8ff5794b));
		repeat (8) @(negedge i_mclk);
		i_nrst = 1'b1;
		rd_reg(TMC_CTRL_ADDR, r);
		chk("ctrl reset", r, TMC_CTRL_RST);
		// run bit kept low so no stray overflow lands in the flags
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom) & 8'hFB;
			wr_reg(TMC_CTRL_ADDR, v);
			rd_reg(TMC_CTRL_ADDR, r);
			chk("ctrl rw", r, v);
		end
		wr_reg(TMC_CTRL_ADDR, 8'h00);
		page = 4'h1;
		wr_reg(TMC_CTRL_ADDR, 8'hFF);
		rd_reg(TMC_CTRL_ADDR, r);
		chk("other page read", r, 8'h00);
		page = 4'h0;
		rd_reg(TMC_CTRL_ADDR, r);
		chk("other page write", r, 8'h00);
		for (int b = 0; b < 8; b++) begin
			bit_wr(3'(b), 1'b1);
			rd_reg(TMC_CTRL_ADDR, r);
			chk("bit set", r, 8'h01 << b);
			bit_wr(3'(b), 1'b0);
		end
		// 16-bit wrap from FFFE, reload kept low so no second low wrap
		v = 8'($urandom) & 8'h7F;
		rh = 8'($urandom);
		wr_reg(TMC_RLL_ADDR, v);
		wr_reg(TMC_RLH_ADDR, rh);
		wr_reg(TMC_CNTL_ADDR, 8'hFE);
		wr_reg(TMC_CNTH_ADDR, 8'hFF);
		{lo_sel, hi_sel, core_en} = 3'b111;
		wr_reg(TMC_CTRL_ADDR, 8'h04);
		repeat (12) @(negedge i_mclk);
		chk("irq on wrap", {7'h00, irq}, 8'h01);
		rd_reg(TMC_CTRL_ADDR, r);
		chk("wrap flags", r, 8'hC4);
		core_en = 1'b0;
		repeat (2) @(negedge i_mclk);
		chk("irq core off", {7'h00, irq}, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h00);
		rd_reg(TMC_CNTH_ADDR, r);
		chk("reload high", r, rh);
		// split: low runs with run clear, high must stay put
		wr_reg(TMC_CNTL_ADDR, 8'hFD);
		wr_reg(TMC_CNTH_ADDR, 8'h00);
		wr_reg(TMC_RLL_ADDR, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h08);
		repeat (12) @(negedge i_mclk);
		rd_reg(TMC_CTRL_ADDR, r);
		chk("split flags", r, 8'h48);
		rd_reg(TMC_CNTH_ADDR, r);
		chk("split high held", r, 8'h00);
		core_en = 1'b1;
		repeat (2) @(negedge i_mclk);
		chk("irq low masked", {7'h00, irq}, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h68);
		repeat (2) @(negedge i_mclk);
		chk("irq low enabled", {7'h00, irq}, 8'h01);
		// capture: select 10 must ignore rtc and trigger on comparator
		{core_en, hi_sel} = 2'b00;
		wr_reg(TMC_CTRL_ADDR, 8'h00);
		wr_reg(TMC_CNTL_ADDR, 8'h00);
		wr_reg(TMC_CNTH_ADDR, 8'h00);
		wr_reg(TMC_RLH_ADDR, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h16);
		pulse(1'b0, 8);
		rd_reg(TMC_CTRL_ADDR, r);
		chk("rtc ignored", r, 8'h16);
		pulse(1'b1, 1);
		rd_reg(TMC_CTRL_ADDR, r);
		chk("cmp capture", r, 8'h96);
		rd_reg(TMC_RLL_ADDR, r);
		chk("captured low", {7'h00, r == 8'h00}, 8'h00);
		wr_reg(TMC_CNTL_ADDR, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h14);
		pulse(1'b0, 8);
		rd_reg(TMC_CTRL_ADDR, r);
		chk("rtc capture", r, 8'h94);
		// select 01 counts comparator rises, select 11 counts rtc/8
		lo_sel = 1'b0;
		wr_reg(TMC_CTRL_ADDR, 8'h00);
		wr_reg(TMC_CNTL_ADDR, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h05);
		pulse(1'b1, 3);
		rd_reg(TMC_CNTL_ADDR, r);
		chk("cmp ext clock", r, 8'h03);
		wr_reg(TMC_CTRL_ADDR, 8'h00);
		wr_reg(TMC_CNTL_ADDR, 8'h00);
		wr_reg(TMC_CTRL_ADDR, 8'h07);
		pulse(1'b0, 8);
		rd_reg(TMC_CNTL_ADDR, r);
		chk("rtc ext clock", r, 8'h01);
		finish_test();
	end
endmodule
`default_nettype wire
